// >>> hdl/tmr_pkg.sv
// Constants, state codes and carrier types of the two-wire master receiver.
// Assumes a 25 MHz system clock and an APB register bus with 32-bit data.
`default_nettype none
package tmr_pkg;
   // ****************************************
   // Register map and control bit positions
   // ****************************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_DATA = 8'h08;
   localparam logic [7:0] A_RATE = 8'h0c;
   localparam int CB_DONE = 7;
   localparam int CB_ACK = 6;
   localparam int CB_STA = 5;
   localparam int CB_STO = 4;
   localparam int CB_WCOL = 3;
   localparam int CB_EN = 2;
   localparam int CB_IE = 0;
   localparam int SB_PRE = 0;
   // ****************************************
   // Status codes, prescaler field clear
   // ****************************************
   localparam logic [7:0] C_START = 8'h08;
   localparam logic [7:0] C_RSTART = 8'h10;
   localparam logic [7:0] C_MT_AACK = 8'h18;
   localparam logic [7:0] C_MT_ANAK = 8'h20;
   localparam logic [7:0] C_MT_DACK = 8'h28;
   localparam logic [7:0] C_MT_DNAK = 8'h30;
   localparam logic [7:0] C_ARB = 8'h38;
   localparam logic [7:0] C_MR_AACK = 8'h40;
   localparam logic [7:0] C_MR_ANAK = 8'h48;
   localparam logic [7:0] C_MR_DACK = 8'h50;
   localparam logic [7:0] C_MR_DNAK = 8'h58;
   localparam logic [7:0] C_IDLE = 8'hf8;
   // ****************************************
   // Reset values and timing
   // ****************************************
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [1:0] RST_PRE = 2'h0;
   localparam int CLK_NS = 40;
   localparam int LINK_NS = 320;
   localparam int QTR_CYC = LINK_NS / (4 * CLK_NS);
   localparam logic [7:0] RST_RATE = 8'(QTR_CYC - 1);
   localparam int QW = 16;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      BC_START = 2'h0,
      BC_STOP = 2'h1,
      BC_WR = 2'h2,
      BC_RD = 2'h3
   } tmr_bcmd_t;
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_WFREE = 7'h02,
      S_START = 7'h04,
      S_HOLD = 7'h08,
      S_BITS = 7'h10,
      S_ACK = 7'h20,
      S_STOP = 7'h40
   } tmr_state_t;
   typedef struct packed {
      logic scl;
      logic sda;
   } tmr_pins_t;
endpackage
`default_nettype wire

// >>> hdl/tmr_sync2.sv
// Two-flop synchroniser for the bus line levels.
// Assumes inputs idle high, as pulled-up open-drain lines do.
`timescale 1ns/1ps
`default_nettype none
module tmr_sync2 #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   generate
      if (W < 1) begin : g_chk
         $error("tmr_sync2 needs W of at least 1");
      end
   endgenerate
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_ff <= '1;
         q <= '1;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/tmr_bitgen.sv
// Bit engine: one START, STOP or data bit in four quarter phases.
// Assumes synchronised line levels and a go pulse only while idle.
`timescale 1ns/1ps
`default_nettype none
module tmr_bitgen #(
   parameter int QW = tmr_pkg::QW
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic en,
   // Command
   input wire logic go,
   input wire tmr_pkg::tmr_bcmd_t cmd,
   input wire logic val,
   input wire logic [QW-1:0] qtr,
   // Lines, release means not pulled low
   input wire tmr_pkg::tmr_pins_t line,
   output tmr_pkg::tmr_pins_t rel,
   // Result
   output logic busy,
   output logic done,
   output logic rx,
   output logic arb
);
   import tmr_pkg::*;
   tmr_bcmd_t cmd_ff;
   logic val_ff;
   logic [1:0] ph_ff;
   logic [QW-1:0] cnt_ff;
   logic want_scl;
   logic want_sda;
   logic is_bit;
   logic stretch;
   logic tick;
   generate
      if (QW < 15) begin : g_chk
         $error("tmr_bitgen needs QW of at least 15");
      end
   endgenerate
   // ****************************************
   // Phase tables
   // ****************************************
   // For START and STOP, phase 0 keeps SCL as it is, so a repeated START never makes a STOP.
   assign is_bit = (cmd_ff == BC_WR) || (cmd_ff == BC_RD);
   assign want_scl = (ph_ff == 2'd0) ? (!is_bit && rel.scl) :
                     (ph_ff == 2'd3) ? (cmd_ff == BC_STOP) : 1'b1;
   assign want_sda = (cmd_ff == BC_START) ? !ph_ff[1] :
                     (cmd_ff == BC_STOP) ? ph_ff[1] :
                     (cmd_ff == BC_WR) ? val_ff : 1'b1;
   // A slave that holds SCL low stretches phase 1, the first high phase.
   assign stretch = want_scl && !line.scl && (ph_ff == 2'd1);
   assign tick = busy && !stretch && (cnt_ff == '0);
   always_ff @(posedge clk) begin
      if (srst || !en) begin
         cmd_ff <= BC_START;
         val_ff <= 1'b1;
         ph_ff <= 2'd0;
         cnt_ff <= '0;
         rel <= '1;
         busy <= 1'b0;
         done <= 1'b0;
         rx <= 1'b1;
         arb <= 1'b0;
      end else begin
         done <= 1'b0;
         if (go && !busy) begin
            cmd_ff <= cmd;
            val_ff <= val;
            ph_ff <= 2'd0;
            cnt_ff <= qtr - QW'(1);
            busy <= 1'b1;
            arb <= 1'b0;
         end else if (busy) begin
            rel <= '{scl: want_scl, sda: want_sda};
            if (!stretch) begin
               cnt_ff <= (cnt_ff == '0) ? qtr - QW'(1) : cnt_ff - QW'(1);
            end
            if (tick) begin
               ph_ff <= ph_ff + 2'd1;
               if (ph_ff == 2'd2) begin
                  rx <= line.sda;
                  arb <= (cmd_ff == BC_WR) && val_ff && !line.sda;
               end
               if (ph_ff == 2'd3) begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  if (arb) begin
                     rel <= '1;
                  end
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> hdl/tmr_top.sv
// Two-wire master receiver with master transmitter fallback and APB registers.
// Assumes open-drain SCL and SDA with pull-ups outside; pins are asynchronous.
//
// Behaviour
// - A requested START waits until the bus is free, then goes out.
// - After START the done flag sets and status reads 0x08.
// - Address direction bit selects transmitter or receiver mode.
// - After read address and its acknowledge, done sets; status 0x38, 0x40 or 0x48.
// - Each received byte is readable in data once done sets after it.
// - In 0x40 or 0x50 clearing done receives a byte; ACK follows ack enable.
// - After repeated START, status 0x10, the bus stays owned.
// - In 0x10, write-direction address plus clearing done enters transmitter mode.
// - Status 0x38: release bus, or START again once free if start set.
// - In 0x48 or 0x58: start gives repeated START, stop gives STOP, both both.
// - A STOP sent clears the stop request bit in hardware, unless a control write lands in the same cycle.
// - Done is cleared by writing one; the bus resumes only after that.
`timescale 1ns/1ps
`default_nettype none
module tmr_top (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Two-wire bus, output enables active low
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   import tmr_pkg::*;
   // ****************************************
   // Declarations
   // ****************************************
   tmr_state_t state_ff, nxt_state;
   logic op_done_ff, ack_en_ff, sta_ff, sto_ff, wcol_ff, en_ff, ie_ff;
   logic [7:0] code_ff, nxt_code;
   logic [1:0] presc_ff;
   logic [7:0] data_ff, rate_ff, rd_mux;
   logic owner_ff, nxt_owner, rx_mode_ff, nxt_rx, addr_ff, nxt_addr;
   logic [2:0] bitcnt_ff, nxt_cnt;
   logic then_ff, nxt_then, set_done, clr_sto, kick_ff, busy_ff;
   tmr_pins_t line, line_d_ff, rel;
   logic wr_en, rd_setup, hit_ctrl, hit_stat, hit_data, hit_rate;
   logic ctrl_wr, stat_wr, data_wr, rate_wr, kick;
   logic start_seen, stop_seen, bus_free, tx, cont_ok, active;
   logic bg_go, bg_val, bg_busy, bg_done, bg_rx, bg_arb;
   tmr_bcmd_t bg_cmd;
   logic [QW-1:0] qtr;
   // ****************************************
   // APB decode
   // ****************************************
   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign hit_ctrl = (paddr == A_CTRL);
   assign hit_stat = (paddr == A_STAT);
   assign hit_data = (paddr == A_DATA);
   assign hit_rate = (paddr == A_RATE);
   assign ctrl_wr = wr_en && hit_ctrl;
   assign stat_wr = wr_en && hit_stat;
   assign data_wr = wr_en && hit_data;
   assign rate_wr = wr_en && hit_rate;
   // A control write with done and enable set is the go command.
   assign kick = ctrl_wr && pwdata[CB_DONE] && pwdata[CB_EN];
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(hit_ctrl || hit_stat || hit_data || hit_rate);
   assign rd_mux = hit_ctrl ? {op_done_ff, ack_en_ff, sta_ff, sto_ff, wcol_ff,
                               en_ff, 1'b0, ie_ff} :
                   hit_stat ? {code_ff[7:3], 1'b0, presc_ff} :
                   hit_data ? data_ff :
                   hit_rate ? rate_ff : 8'h00;
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= {24'h00_0000, rd_mux};
      end
   end
   // ****************************************
   // Line synchronisers and bus monitor
   // ****************************************
   tmr_sync2 #(
      .W(2)
   ) u_sync (
      .clk(clk),
      .srst(srst),
      .d({scl_i, sda_i}),
      .q(line)
   );
   assign start_seen = line.scl && line_d_ff.sda && !line.sda;
   assign stop_seen = line.scl && !line_d_ff.sda && line.sda;
   assign bus_free = !busy_ff && line.scl && line.sda;
   always_ff @(posedge clk) begin
      if (srst) begin
         line_d_ff <= '1;
         busy_ff <= 1'b0;
      end else begin
         line_d_ff <= line;
         busy_ff <= start_seen || (busy_ff && !stop_seen);
      end
   end
   // ****************************************
   // Bit engine
   // ****************************************
   // The prescaler scales the quarter period by four per step.
   assign qtr = (QW'(rate_ff) + QW'(1)) << {presc_ff, 1'b0};
   assign tx = addr_ff || !rx_mode_ff;
   assign active = (state_ff == S_START) || (state_ff == S_STOP) ||
                   (state_ff == S_BITS) || (state_ff == S_ACK);
   assign bg_go = active && !bg_busy && !bg_done;
   assign bg_cmd = (state_ff == S_START) ? BC_START :
                   (state_ff == S_STOP) ? BC_STOP :
                   (state_ff == S_BITS) ? (tx ? BC_WR : BC_RD) :
                   (tx ? BC_RD : BC_WR);
   assign bg_val = (state_ff == S_BITS) ? data_ff[7] : !ack_en_ff;
   tmr_bitgen #(
      .QW(QW)
   ) u_bit (
      .clk(clk),
      .srst(srst),
      .en(en_ff),
      .go(bg_go),
      .cmd(bg_cmd),
      .val(bg_val),
      .qtr(qtr),
      .line(line),
      .rel(rel),
      .busy(bg_busy),
      .done(bg_done),
      .rx(bg_rx),
      .arb(bg_arb)
   );
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_n = rel.scl;
   assign sda_oe_n = rel.sda;
   // ****************************************
   // Transfer sequencer
   // ****************************************
   assign cont_ok = (code_ff == C_MR_AACK) || (code_ff == C_MR_DACK) ||
                    (code_ff == C_MT_AACK) || (code_ff == C_MT_ANAK) ||
                    (code_ff == C_MT_DACK) || (code_ff == C_MT_DNAK);
   always_comb begin
      nxt_state = state_ff;
      nxt_code = code_ff;
      nxt_owner = owner_ff;
      nxt_rx = rx_mode_ff;
      nxt_addr = addr_ff;
      nxt_cnt = bitcnt_ff;
      nxt_then = then_ff;
      set_done = 1'b0;
      clr_sto = 1'b0;
      unique case (state_ff)
         S_IDLE: begin
            if (kick_ff && sta_ff) begin
               nxt_state = S_WFREE;
            end
         end
         S_WFREE: begin
            if (bus_free) begin
               nxt_state = S_START;
            end
         end
         S_START: begin
            if (bg_done) begin
               nxt_state = S_HOLD;
               set_done = 1'b1;
               nxt_owner = 1'b1;
               nxt_code = owner_ff ? C_RSTART : C_START;
            end
         end
         S_HOLD: begin
            if (kick_ff) begin
               if (code_ff == C_ARB || !owner_ff) begin
                  nxt_state = sta_ff ? S_WFREE : S_IDLE;
                  nxt_code = C_IDLE;
               end else if (sto_ff) begin
                  nxt_state = S_STOP;
                  nxt_then = sta_ff;
               end else if (sta_ff) begin
                  nxt_state = S_START;
               end else if (code_ff == C_START || code_ff == C_RSTART) begin
                  nxt_state = S_BITS;
                  nxt_addr = 1'b1;
                  nxt_rx = data_ff[0];
                  nxt_cnt = 3'd0;
               end else if (cont_ok) begin
                  nxt_state = S_BITS;
                  nxt_addr = 1'b0;
                  nxt_cnt = 3'd0;
               end
            end
         end
         S_BITS: begin
            if (bg_done) begin
               if (bg_arb) begin
                  nxt_state = S_HOLD;
                  nxt_code = C_ARB;
                  nxt_owner = 1'b0;
                  set_done = 1'b1;
               end else if (bitcnt_ff == 3'd7) begin
                  nxt_state = S_ACK;
               end else begin
                  nxt_cnt = bitcnt_ff + 3'd1;
               end
            end
         end
         S_ACK: begin
            if (bg_done) begin
               nxt_state = S_HOLD;
               set_done = 1'b1;
               if (bg_arb) begin
                  nxt_code = C_ARB;
                  nxt_owner = 1'b0;
               end else if (addr_ff) begin
                  nxt_code = rx_mode_ff ? (bg_rx ? C_MR_ANAK : C_MR_AACK) :
                             (bg_rx ? C_MT_ANAK : C_MT_AACK);
               end else if (rx_mode_ff) begin
                  nxt_code = ack_en_ff ? C_MR_DACK : C_MR_DNAK;
               end else begin
                  nxt_code = bg_rx ? C_MT_DNAK : C_MT_DACK;
               end
            end
         end
         S_STOP: begin
            if (bg_done) begin
               clr_sto = 1'b1;
               nxt_owner = 1'b0;
               nxt_code = C_IDLE;
               nxt_state = then_ff ? S_WFREE : S_IDLE;
            end
         end
         default: begin
            nxt_state = S_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (srst || !en_ff) begin
         state_ff <= S_IDLE;
         code_ff <= C_IDLE;
         owner_ff <= 1'b0;
         rx_mode_ff <= 1'b0;
         addr_ff <= 1'b0;
         bitcnt_ff <= 3'd0;
         then_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         code_ff <= nxt_code;
         owner_ff <= nxt_owner;
         rx_mode_ff <= nxt_rx;
         addr_ff <= nxt_addr;
         bitcnt_ff <= nxt_cnt;
         then_ff <= nxt_then;
      end
   end
   // ****************************************
   // Registers
   // ****************************************
   // The done flag set by hardware wins over a clearing write in the same cycle.
   always_ff @(posedge clk) begin
      if (srst) begin
         {op_done_ff, ack_en_ff, sta_ff, sto_ff, wcol_ff, en_ff, ie_ff} <= '0;
         presc_ff <= RST_PRE;
         rate_ff <= RST_RATE;
         data_ff <= RST_CTRL;
         kick_ff <= 1'b0;
      end else begin
         kick_ff <= kick;
         op_done_ff <= set_done || (op_done_ff && !(ctrl_wr && pwdata[CB_DONE]));
         if (ctrl_wr) begin
            ack_en_ff <= pwdata[CB_ACK];
            sta_ff <= pwdata[CB_STA];
            sto_ff <= pwdata[CB_STO];
            en_ff <= pwdata[CB_EN];
            ie_ff <= pwdata[CB_IE];
         end else if (clr_sto) begin
            sto_ff <= 1'b0;
         end
         if (stat_wr) begin
            presc_ff <= pwdata[SB_PRE+1:SB_PRE];
         end
         if (rate_wr) begin
            rate_ff <= pwdata[7:0];
         end
         // A data write lands only while the bus waits, else it collides.
         if (state_ff == S_BITS && bg_done) begin
            data_ff <= {data_ff[6:0], bg_rx};
         end else if (data_wr && (op_done_ff || state_ff == S_IDLE)) begin
            data_ff <= pwdata[7:0];
         end
         if (data_wr) begin
            wcol_ff <= !(op_done_ff || state_ff == S_IDLE);
         end
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   chk_free_start: assert property (
      (bg_go && state_ff == S_START && !owner_ff) |-> $past(bus_free))
      else $error("START issued while the bus was not free");
   chk_start_code: assert property (
      (state_ff == S_START && bg_done && !owner_ff) |=> op_done_ff && code_ff == C_START)
      else $error("START did not report 0x08 with done set");
   chk_rstart_own: assert property (
      (state_ff == S_START && bg_done && owner_ff) |=> owner_ff && code_ff == C_RSTART)
      else $error("repeated START lost the bus or its code");
   chk_addr_codes: assert property (
      (state_ff == S_ACK && bg_done && addr_ff && rx_mode_ff) |=>
      op_done_ff && (code_ff == C_ARB || code_ff == C_MR_AACK || code_ff == C_MR_ANAK))
      else $error("read address gave a wrong status");
   chk_ack_level: assert property (
      (state_ff == S_ACK && !tx && bg_busy && scl_oe_n) |-> sda_oe_n == !ack_en_ff)
      else $error("returned acknowledge does not follow ack enable");
   chk_no_resume: assert property (
      op_done_ff |-> !bg_go)
      else $error("bus moved while done was set");
   chk_stop_clear: assert property (
      (state_ff == S_STOP && bg_done && !ctrl_wr) |=> !sto_ff ##1 !scl_oe_n == 1'b0)
      else $error("STOP did not clear the stop request");
   chk_scl_low: assert property (
      (state_ff == S_HOLD && op_done_ff && owner_ff) |-> !scl_oe_n)
      else $error("SCL not held low while waiting");
   chk_arb_code: assert property (
      (bg_done && bg_arb && (state_ff == S_BITS || state_ff == S_ACK)) |=>
      code_ff == C_ARB && !owner_ff ##1 scl_oe_n && sda_oe_n)
      else $error("lost arbitration not reported or bus kept");
   cov_rx_byte: cover property (state_ff == S_ACK && bg_done && rx_mode_ff && !addr_ff);
   cov_rstart: cover property (state_ff == S_START && bg_done && owner_ff);
   cov_arb: cover property (bg_done && bg_arb);
   cov_stop: cover property (state_ff == S_STOP && bg_done);
endmodule
`default_nettype wire

// >>> sim/tmr_slave_model.sv
// Slave transmitter model on the two-wire bus: it acks its address and sends bytes.
// Assumes pulled-up lines, so a released line reads high.
`timescale 1ns/1ps
`default_nettype none
module tmr_slave_model #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   // Bus lines and byte seed
   input wire logic scl,
   input wire logic sda,
   input wire logic [7:0] seed,
   input wire logic slow,
   // Releases, low pulls the line
   output logic sda_rel,
   output logic scl_rel
);
   // ****************************************
   // Framing, shifting and stretching
   // ****************************************
   logic [1:0] md = 2'h0;
   logic [3:0] cnt = 4'h0;
   logic [7:0] sh = 8'h00;
   logic [7:0] tx = 8'h00;
   logic [7:0] k = 8'h00;
   initial sda_rel = 1'b1;
   initial scl_rel = 1'b1;
   always @(negedge sda) if (scl) begin
      md <= 2'h1;
      cnt <= 4'h0;
      k <= 8'h00;
   end
   always @(posedge sda) if (scl) md <= 2'h0;
   always @(posedge scl) begin
      if (cnt < 4'h8) sh <= {sh[6:0], sda};
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h8) begin
         tx <= seed + k * 8'h35;
         k <= k + 8'h1;
         if (md == 2'h1) md <= (sh[0] && sh[7:1] == ADDR) ? 2'h2 : 2'h0;
         if (md == 2'h2 && sda) md <= 2'h0;
      end
   end
   // Data changes only while the clock is low, so no false START or STOP appears.
   always @(negedge scl) begin
      if (md == 2'h1 && cnt == 4'h8) sda_rel <= sh[7:1] != ADDR;
      else if (md == 2'h2 && cnt != 4'h8) sda_rel <= tx[3'(4'h7 - cnt)];
      else sda_rel <= 1'b1;
      if (slow) begin
         scl_rel = 1'b0;
         #400 scl_rel = 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> sim/tmr_top_bench.sv
// Bench for the two-wire master receiver: random read frames against a slave model.
// Assumes pull-ups on both lines and the slave model at address 0x2a.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
   $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tmr_top_bench;
   import tmr_pkg::*;
   // ****************************************
   // Bench
   // ****************************************
   logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic [7:0] paddr = 8'h00, seed = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n, sda_rel, scl_rel, err;
   int error_cnt = 0, compares = 0;
   wire logic scl = scl_oe_n & scl_rel;
   // A second master that holds SDA low, so that our address loses arbitration.
   logic hog = 1'b0;
   wire logic sda = sda_oe_n & sda_rel & !hog;
   tmr_top i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n));
   tmr_slave_model #(.ADDR(7'h2a)) i_slave (.scl(scl), .sda(sda), .seed(seed),
      .slow(slow), .sda_rel(sda_rel), .scl_rel(scl_rel));
   initial forever #20 clk = ~clk;
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_on(input int bit_n, input logic [7:0] a, input logic [7:0] e);
      int i = 0;
      do begin
         bus(1'b0, a, 8'h00);
         i++;
      end while ((bit_n < 8 ? r[bit_n] : r[7:0]) !== e[0 +: 1] && bit_n < 8 && i < 400 ||
         bit_n == 8 && r[7:0] !== e && i < 400);
   endtask
   task automatic wait_done();
      wait_on(CB_DONE, A_CTRL, 8'h01);
      `CHK(r[CB_DONE], 1'b1)
      `CHK(scl_oe_n, 1'b0)
   endtask
   task automatic stat(input logic [7:0] e);
      bus(1'b0, A_STAT, 8'h00);
      `CHK(r[7:0] & 8'hf8, e)
   endtask
   function automatic logic [7:0] exp_byte(input logic [7:0] s, input int i);
      return s + 8'(i) * 8'h35;
   endfunction
   task automatic summarize();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      error_cnt++;
      summarize();
   end
   initial begin
      int n;
      logic own;
      own = 1'b0;
      void'($urandom(32'h949a));
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      bus(1'b0, A_CTRL, 8'h00);
      `CHK(r[7:0], RST_CTRL)
      `CHK({scl_o, sda_o, scl_oe_n, sda_oe_n}, 4'b0011)
      bus(1'b0, A_RATE, 8'h00);
      `CHK(r[7:0], RST_RATE)
      bus(1'b0, 8'h10, 8'h00);
      `CHK({err, r}, {1'b1, 32'h0})
      for (int t = 0; t < 6; t++) begin
         n = 1 + $urandom_range(2);
         slow <= 1'($urandom_range(1));
         seed <= 8'($urandom);
         if (!own) begin
            bus(1'b1, A_CTRL, 8'ha4);
            wait_done();
            stat(C_START);
         end
         bus(1'b1, A_DATA, {(t == 0) ? 7'h15 : 7'h2a, 1'b1});
         bus(1'b1, A_CTRL, 8'h84);
         wait_done();
         if (t == 0) begin
            stat(C_MR_ANAK);
            bus(1'b1, A_CTRL, 8'hb4);
            wait_done();
            stat(C_START);
            bus(1'b0, A_CTRL, 8'h00);
            `CHK(r[CB_STO], 1'b0)
            own = 1'b1;
            continue;
         end
         stat(C_MR_AACK);
         for (int i = 0; i < n; i++) begin
            bus(1'b1, A_CTRL, (i < n - 1) ? 8'hc4 : 8'h84);
            wait_done();
            stat((i < n - 1) ? C_MR_DACK : C_MR_DNAK);
            bus(1'b0, A_DATA, 8'h00);
            `CHK(r[7:0], exp_byte(seed, i))
         end
         own = t[0];
         if (own) begin
            bus(1'b1, A_CTRL, 8'ha4);
            wait_done();
            stat(C_RSTART);
         end else begin
            bus(1'b1, A_CTRL, 8'h94);
            wait_on(8, A_STAT, C_IDLE);
            stat(C_IDLE);
            bus(1'b0, A_CTRL, 8'h00);
            `CHK({r[CB_STO], scl_oe_n, sda_oe_n}, 3'b011)
         end
      end
      bus(1'b1, A_DATA, 8'h54);
      bus(1'b1, A_CTRL, 8'h84);
      wait_done();
      stat(C_MT_AACK);
      bus(1'b1, A_CTRL, 8'h04);
      repeat (40) @(posedge clk);
      stat(C_MT_AACK);
      `CHK(scl_oe_n, 1'b0)
      bus(1'b1, A_CTRL, 8'ha4);
      wait_done();
      stat(C_RSTART);
      hog <= 1'b1;
      bus(1'b1, A_DATA, 8'h55);
      bus(1'b1, A_CTRL, 8'h84);
      wait_on(CB_DONE, A_CTRL, 8'h01);
      stat(C_ARB);
      `CHK({scl_oe_n, sda_oe_n}, 2'b11)
      bus(1'b1, A_CTRL, 8'ha4);
      repeat (40) @(posedge clk);
      bus(1'b0, A_CTRL, 8'h00);
      `CHK(r[CB_DONE], 1'b0)
      hog <= 1'b0;
      wait_done();
      stat(C_START);
      bus(1'b1, A_CTRL, 8'h00);
      bus(1'b0, A_CTRL, 8'h00);
      `CHK({scl_oe_n, sda_oe_n}, 2'b11)
      summarize();
   end
endmodule
`default_nettype wire
